/* File: logic/sram_port_pkg.sv */
/*
 * shared constants, types and burst-order arithmetic for the
 * pipelined burst sram port.
 * assumes a single 50 mhz clock domain and no software registers.
 */
`default_nettype none
package sram_port_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int LANES  = 4;
    localparam int LANE_W = 8;
    localparam int DEPTH  = 65536;
    localparam int CNT_W  = 2;
    localparam int HI_W   = ADDR_W - CNT_W;

    localparam logic [CNT_W-1:0]  CNT_RST  = 2'h0;
    localparam logic [LANES-1:0]  BE_ALL   = 4'hf;
    localparam logic [LANES-1:0]  BE_NONE  = 4'h0;
    localparam logic [DATA_W-1:0] DATA_RST = 32'h0;
    localparam logic [HI_W-1:0]   HI_RST   = 14'h0;
    localparam logic              DRV_RST  = 1'b1;
    localparam logic              STRAP_RST = 1'b1;

    typedef enum logic [1:0] {
        ACC_DESEL,
        ACC_READ,
        ACC_WRITE
    } acc_t;

    // interleaved order is start xor step, linear is start plus step
    function automatic logic [CNT_W-1:0] burst_lo(input logic             linear,
                                                  input logic [CNT_W-1:0] start,
                                                  input logic [CNT_W-1:0] cnt);
        logic [CNT_W-1:0] sum;
        sum = start + cnt;
        return linear ? sum : (start ^ cnt);
    endfunction
endpackage
`default_nettype wire

/* File: logic/burst_counter.sv */
/*
 * two-bit wraparound burst counter: holds the start address bits and
 * a step count, and produces the low address of each burst beat.
 * assumes load and step are never requested together.
 */
`timescale 1ns/1ps
`default_nettype none
module burst_counter
    import sram_port_pkg::*;
(
    input  wire logic             clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             clk_en_in,
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] start_in,
    input  wire logic             step_in,
    input  wire logic             linear_in,
    output logic      [CNT_W-1:0] addr_lo_out
);
    typedef struct packed {
        logic [CNT_W-1:0] start;
        logic [CNT_W-1:0] cnt;
    } cnt_state_t;

    cnt_state_t st_ff;
    cnt_state_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (load_in) begin
            nxt_st.start = start_in;
            nxt_st.cnt   = CNT_RST;
        end else if (step_in) begin
            // wraps inside the four-word block
            nxt_st.cnt = st_ff.cnt + 2'h1;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else if (clk_en_in) begin
            st_ff <= nxt_st;
        end
    end

    assign addr_lo_out = burst_lo(linear_in, st_ff.start, st_ff.cnt);
endmodule
`default_nettype wire

/* File: logic/sram_core.sv */
/*
 * 64k x 32 storage with per-lane write enables and a registered read port.
 * assumes one access per enabled clock; a read of the word being written
 * returns the old contents.
 */
`timescale 1ns/1ps
`default_nettype none
module sram_core
    import sram_port_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              clk_en_in,
    input  wire logic              we_in,
    input  wire logic [LANES-1:0]  be_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic [DATA_W-1:0] wdata_in,
    output logic      [DATA_W-1:0] rdata_out
);
    logic [DATA_W-1:0] mem [DEPTH];

    // no reset on the array or its read register: contents must survive
    always_ff @(posedge clk_in) begin
        if (clk_en_in) begin
            rdata_out <= mem[addr_in];
            for (int i = 0; i < LANES; i++) begin
                if (we_in && be_in[i]) begin
                    mem[addr_in][i*LANE_W +: LANE_W] <= wdata_in[i*LANE_W +: LANE_W];
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/pipelined_burst_sram_port.sv */
/*
 * device side of a pipelined burst sram port: strobe decode, chip
 * selects, burst addressing, byte and global writes, output drive
 * control and sleep.
 * assumes the bus logic runs on clk_in; output enable, sleep and the
 * burst-order strap arrive from pins and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none
module pipelined_burst_sram_port
    import sram_port_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              clk_en_in,
    input  wire logic [ADDR_W-1:0] addr_in,
    input  wire logic              proc_addr_strobe_n_in,
    input  wire logic              ctrl_addr_strobe_n_in,
    input  wire logic              burst_step_n_in,
    input  wire logic              chip_sel_a_n_in,
    input  wire logic              chip_sel_b_in,
    input  wire logic              chip_sel_c_n_in,
    input  wire logic              global_write_n_in,
    input  wire logic              byte_wr_enable_n_in,
    input  wire logic [LANES-1:0]  byte_lane_sel_n_in,
    input  wire logic              out_en_n_in,
    input  wire logic              sleep_req_in,
    input  wire logic              burst_order_in,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic                   dq_oe_n_out,
    output logic                   sleeping_out
);
    typedef struct packed {
        logic              oe_n_s1;
        logic              oe_n_s2;
        logic              slp_s1;
        logic              slp_s2;
        logic              strap_s1;
        logic              strap_s2;
        logic              sleeping;
        acc_t              acc;
        logic [HI_W-1:0]   addr_hi;
        logic [DATA_W-1:0] wr_data;
        logic [LANES-1:0]  wr_be;
        logic              drv_n;
    } port_state_t;

    port_state_t st_ff;
    port_state_t nxt_st;

    logic             selected;
    logic             proc_take;
    logic             ctrl_take;
    logic             take;
    logic             wr_req;
    logic [LANES-1:0] wr_be_now;
    logic             active;
    logic             cont;
    logic             step;
    logic             load;
    logic             linear;
    logic             mem_we;
    logic [CNT_W-1:0] addr_lo;
    logic [DATA_W-1:0] rdata;

    assign selected  = !chip_sel_a_n_in && chip_sel_b_in && !chip_sel_c_n_in;
    assign proc_take = !proc_addr_strobe_n_in && !chip_sel_a_n_in;
    assign ctrl_take = !ctrl_addr_strobe_n_in && !proc_take;
    assign take      = (proc_take || ctrl_take) && !st_ff.sleeping;
    assign load      = take && selected;
    assign active    = st_ff.acc != ACC_DESEL;
    assign cont      = !take && active && !st_ff.sleeping;
    assign step      = cont && !burst_step_n_in;
    assign linear    = !st_ff.strap_s2;

    // global write overrides the byte controls
    assign wr_req = !global_write_n_in
                    || (!byte_wr_enable_n_in && (byte_lane_sel_n_in != BE_ALL));

    always_comb begin
        wr_be_now = BE_NONE;
        if (!global_write_n_in) begin
            wr_be_now = BE_ALL;
        end else if (!byte_wr_enable_n_in) begin
            wr_be_now = ~byte_lane_sel_n_in;
        end
    end

    always_comb begin
        nxt_st = st_ff;
        // first stage feeds only the second stage
        nxt_st.oe_n_s1  = out_en_n_in;
        nxt_st.oe_n_s2  = st_ff.oe_n_s1;
        nxt_st.slp_s1   = sleep_req_in;
        nxt_st.slp_s2   = st_ff.slp_s1;
        nxt_st.strap_s1 = burst_order_in;
        nxt_st.strap_s2 = st_ff.strap_s1;
        nxt_st.sleeping = st_ff.slp_s2;
        nxt_st.wr_data  = dq_in;
        nxt_st.wr_be    = wr_be_now;

        unique case (st_ff.acc)
            ACC_DESEL,
            ACC_READ,
            ACC_WRITE: begin
                if (st_ff.sleeping) begin
                    // pending work is dropped, the array is left alone
                    nxt_st.acc = ACC_DESEL;
                end else if (take) begin
                    if (selected) begin
                        nxt_st.addr_hi = addr_in[ADDR_W-1:CNT_W];
                        // processor strobe ignores write controls this cycle
                        nxt_st.acc = (ctrl_take && wr_req) ? ACC_WRITE : ACC_READ;
                    end else begin
                        nxt_st.acc = ACC_DESEL;
                    end
                end else if (active) begin
                    // second clock of a processor write lands here
                    nxt_st.acc = wr_req ? ACC_WRITE : ACC_READ;
                end
            end
        endcase

        // drive only the data of a read beat, never on write or deselect
        nxt_st.drv_n = !((st_ff.acc == ACC_READ)
                         && !st_ff.oe_n_s2
                         && (nxt_st.acc != ACC_WRITE)
                         && (nxt_st.acc != ACC_DESEL)
                         && !st_ff.slp_s2
                         && !st_ff.sleeping);
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_ff          <= '0;
            st_ff.acc      <= ACC_DESEL;
            st_ff.addr_hi  <= HI_RST;
            st_ff.wr_data  <= DATA_RST;
            st_ff.strap_s1 <= STRAP_RST;
            st_ff.strap_s2 <= STRAP_RST;
            st_ff.drv_n    <= DRV_RST;
        end else if (clk_en_in) begin
            st_ff <= nxt_st;
        end
    end

    burst_counter i_burst_counter (
        .clk_in      (clk_in),
        .rst_b_in    (rst_b_in),
        .clk_en_in   (clk_en_in),
        .load_in     (load),
        .start_in    (addr_in[CNT_W-1:0]),
        .step_in     (step),
        .linear_in   (linear),
        .addr_lo_out (addr_lo)
    );

    assign mem_we = (st_ff.acc == ACC_WRITE) && !st_ff.sleeping;

    // address bits above the counter stay fixed for the whole burst
    sram_core i_sram_core (
        .clk_in    (clk_in),
        .clk_en_in (clk_en_in),
        .we_in     (mem_we),
        .be_in     (st_ff.wr_be),
        .addr_in   ({st_ff.addr_hi, addr_lo}),
        .wdata_in  (st_ff.wr_data),
        .rdata_out (rdata)
    );

    assign dq_out       = rdata;
    assign dq_oe_n_out  = st_ff.drv_n;
    assign sleeping_out = st_ff.sleeping;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_addr_capture: assert property (clk_en_in && load && !st_ff.sleeping
        |=> st_ff.addr_hi == $past(addr_in[ADDR_W-1:CNT_W])
            && addr_lo == $past(addr_in[CNT_W-1:0]))
        else $error("strobe did not capture the address");

    a_ce_a_gate: assert property (clk_en_in && chip_sel_a_n_in
        && ctrl_addr_strobe_n_in && !proc_addr_strobe_n_in
        |=> $stable(st_ff.addr_hi))
        else $error("processor strobe acted while select a was high");

    a_proc_priority: assert property (clk_en_in && load && proc_take
        && !ctrl_addr_strobe_n_in && !st_ff.sleeping
        |=> st_ff.acc == ACC_READ)
        else $error("controller strobe acted beside processor strobe");

    a_ctrl_global: assert property (clk_en_in && load && ctrl_take
        && !global_write_n_in && !st_ff.sleeping
        |=> mem_we && st_ff.wr_be == BE_ALL ##1 $past(mem_we))
        else $error("controller global write not done in one clock");

    a_byte_lanes: assert property (clk_en_in && cont && global_write_n_in
        && !byte_wr_enable_n_in && byte_lane_sel_n_in != BE_ALL
        |=> st_ff.acc == ACC_WRITE && st_ff.wr_be == ~$past(byte_lane_sel_n_in))
        else $error("byte write lanes wrong");

    a_proc_write: assert property (clk_en_in && load && proc_take
        && !st_ff.sleeping ##1 clk_en_in && cont && !global_write_n_in
        |=> mem_we && $past(st_ff.acc) == ACC_READ)
        else $error("processor write did not take two clocks");

    a_wr_release: assert property (clk_en_in && mem_we
        |-> dq_oe_n_out)
        else $error("pins driven during a write");

    a_first_mask: assert property (clk_en_in && load && !active
        |=> dq_oe_n_out ##1 (dq_oe_n_out || $past(st_ff.acc) == ACC_READ))
        else $error("output enable not masked on first read");

    a_oe_off: assert property (clk_en_in && st_ff.oe_n_s2
        |=> dq_oe_n_out)
        else $error("pins driven with output enable high");

    a_read_drive: assert property (clk_en_in && st_ff.acc == ACC_READ
        && !st_ff.oe_n_s2 && cont && !wr_req && !st_ff.slp_s2
        |=> !dq_oe_n_out)
        else $error("read data not driven one cycle on");

    a_linear_step: assert property (clk_en_in && step && linear
        |=> addr_lo == $past(addr_lo) + 2'h1)
        else $error("linear burst did not add one");

    a_inter_step: assert property (clk_en_in && load && !linear
        ##1 clk_en_in && step && $stable(linear)
        |=> addr_lo == burst_lo(1'b0, $past(addr_lo), 2'h1))
        else $error("interleaved burst step wrong");

    a_hi_hold: assert property (clk_en_in && !load
        |=> $stable(st_ff.addr_hi))
        else $error("upper address moved inside a burst");

    a_sleep_quiet: assert property (st_ff.sleeping
        |-> !mem_we && dq_oe_n_out && sleeping_out)
        else $error("activity while asleep");

    c_ctrl_write: cover property (clk_en_in && load && ctrl_take && wr_req);
    c_proc_burst: cover property (load && proc_take ##1 step [*3]);
    c_read_drive: cover property (st_ff.acc == ACC_READ ##1 !dq_oe_n_out);
    c_sleep: cover property (st_ff.sleeping ##1 !st_ff.sleeping);
endmodule
`default_nettype wire

/* File: test/shared_bus_model.sv */
/*
 * shared data bus seen from the processor and cache controller side:
 * resolves the common data wire from the device drive and the host drive.
 * assumes the host only drives while presenting write data.
 */
`timescale 1ns/1ps
`default_nettype none
module shared_bus_model
    import sram_port_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic [DATA_W-1:0] dev_data_in,
    input  wire logic              dev_oe_n_in,
    input  wire logic [DATA_W-1:0] host_data_in,
    input  wire logic              host_drive_in,
    output logic      [DATA_W-1:0] bus_out
);
    logic [DATA_W-1:0] last_ff = '0;

    // host wins a clash, so a late device release is not caught here
    always_comb begin
        if (host_drive_in) begin
            bus_out = host_data_in;
        end else if (!dev_oe_n_in) begin
            bus_out = dev_data_in;
        end else begin
            // released wire toggles so a stale word never passes for data
            bus_out = ~last_ff;
        end
    end

    always_ff @(posedge clk_in) begin
        last_ff <= bus_out;
    end
endmodule
`default_nettype wire

/* File: test/test_pipelined_burst_sram_port.sv */
/*
 * self-checking bench for the pipelined burst sram port: burst orders,
 * byte and global writes, strobe priority, selects, output drive, sleep.
 * assumes the shared bus model in its own file and a 50 mhz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module test_pipelined_burst_sram_port;
    import sram_port_pkg::*;
    localparam logic [2:0] ON = 3'h2;
    logic              clk_in = 1'b0;
    logic              rst_b_in = 1'b0;
    logic [ADDR_W-1:0] addr = '0;
    logic              proc_n = 1'b1;
    logic              ctrl_n = 1'b1;
    logic              step_n = 1'b1;
    logic [2:0]        sel = ON;
    logic              gw_n = 1'b1;
    logic              bwe_n = 1'b1;
    logic [LANES-1:0]  lanes_n = 4'hf;
    logic              oe_n = 1'b1;
    logic              sleep = 1'b0;
    logic              strap = 1'b1;
    logic [DATA_W-1:0] host_data = '0;
    logic              host_drive = 1'b0;
    logic [DATA_W-1:0] bus_w;
    logic [DATA_W-1:0] dq_out;
    logic              dq_oe_n;
    logic              sleeping;
    logic [DATA_W-1:0] ref_mem [0:DEPTH-1];
    int                n_mismatch = 0;
    int                checks = 0;

    initial begin
        forever #10 clk_in = ~clk_in;
    end

    pipelined_burst_sram_port i_pipelined_burst_sram_port (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(1'b1), .addr_in(addr),
        .proc_addr_strobe_n_in(proc_n), .ctrl_addr_strobe_n_in(ctrl_n), .burst_step_n_in(step_n),
        .chip_sel_a_n_in(sel[2]), .chip_sel_b_in(sel[1]), .chip_sel_c_n_in(sel[0]),
        .global_write_n_in(gw_n), .byte_wr_enable_n_in(bwe_n), .byte_lane_sel_n_in(lanes_n),
        .out_en_n_in(oe_n), .sleep_req_in(sleep), .burst_order_in(strap), .dq_in(bus_w),
        .dq_out(dq_out), .dq_oe_n_out(dq_oe_n), .sleeping_out(sleeping));

    shared_bus_model i_shared_bus_model (
        .clk_in(clk_in), .dev_data_in(dq_out), .dev_oe_n_in(dq_oe_n),
        .host_data_in(host_data), .host_drive_in(host_drive), .bus_out(bus_w));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one bus cycle, launched after a rising edge and sampled at the next one
    task automatic bus(input logic p, input logic c, input logic s, input logic [2:0] se, input logic g,
                       input logic b, input logic [3:0] l, input logic [15:0] a, input logic [31:0] d,
                       input logic h);
        @(posedge clk_in);
        proc_n <= p;
        ctrl_n <= c;
        step_n <= s;
        sel <= se;
        gw_n <= g;
        bwe_n <= b;
        lanes_n <= l;
        addr <= a;
        host_data <= d;
        host_drive <= h;
    endtask

    task automatic idle(input int n);
        repeat (n) bus(1'b1, 1'b1, 1'b1, ON, 1'b1, 1'b1, 4'hf, 16'h0, 32'h0, 1'b0);
    endtask

    task automatic do_reset(input logic s);
        @(posedge clk_in);
        rst_b_in <= 1'b0;
        strap <= s;
        repeat (16) @(posedge clk_in);
        rst_b_in <= 1'b1;
        idle(3);
    endtask

    function automatic logic [15:0] beat(input logic [15:0] a, input int i);
        logic [1:0] n;
        n = i[1:0];
        return {a[15:2], strap ? (a[1:0] ^ n) : (a[1:0] + n)};
    endfunction

    task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic g, input logic b,
                      input logic [3:0] l);
        bus(1'b1, 1'b0, 1'b1, ON, g, b, l, a, d, 1'b1);
        bus(1'b1, 1'b1, 1'b1, ON, 1'b1, 1'b1, 4'hf, a, d, 1'b0);
        #1;
        if (!g || (!b && l != 4'hf)) begin
            check({31'h0, dq_oe_n}, 32'h1);
        end
        for (int i = 0; i < 4; i++) begin
            if (!g || (!b && !l[i])) ref_mem[a][8*i +: 8] = d[8*i +: 8];
        end
    endtask

    task automatic rd(input logic [15:0] a, input int n, input logic first, input logic poke);
        bus(1'b1, 1'b0, 1'b1, ON, 1'b1, 1'b1, 4'hf, a, 32'h0, 1'b0);
        // an ignored processor strobe must not end the burst
        bus(!poke, 1'b1, 1'b0, poke ? 3'h6 : ON, 1'b1, 1'b1, 4'hf, ~a, 32'h0, 1'b0);
        #1;
        // the cycle before the first word is the one that is masked
        if (first) begin
            check({31'h0, dq_oe_n}, 32'h1);
        end
        for (int i = 0; i < n; i++) begin
            @(posedge clk_in);
            #1;
            check(dq_out, ref_mem[beat(a, i)]);
            check({31'h0, dq_oe_n}, 32'h0);
        end
    endtask

    task automatic desel(input logic [2:0] se);
        bus(1'b1, 1'b0, 1'b1, se, 1'b1, 1'b1, 4'hf, 16'h0, 32'h0, 1'b0);
        oe_n <= 1'b0;
        idle(3);
        #1;
        check({31'h0, dq_oe_n}, 32'h1);
    endtask

    task automatic s_fill(input logic [15:0] a);
        for (int i = 0; i < 4; i++) begin
            wr(a + 16'(i), 32'h1000_0001 * (i + 1), 1'b0, 1'b1, 4'hf);
        end
    endtask

    task automatic s_order(input logic [15:0] a, input logic [2:0] se);
        desel(se);
        rd(a + 16'h1, 4, 1'b1, 1'b0);
        rd(a + 16'h2, 4, 1'b0, 1'b1);
    endtask

    task automatic s_bytes(input logic [15:0] a);
        wr(a, 32'hdead_beef, 1'b0, 1'b1, 4'hf);
        wr(a, 32'h1234_5678, 1'b1, 1'b0, 4'ha);
        wr(a, 32'hffff_ffff, 1'b1, 1'b1, 4'h0);
        wr(a, 32'h0a0b_0c0d, 1'b0, 1'b0, 4'h7);
        rd(a, 1, 1'b0, 1'b0);
    endtask

    task automatic s_proc(input logic [15:0] a);
        wr(a + 16'h1, 32'h7777_0000, 1'b0, 1'b1, 4'hf);
        bus(1'b0, 1'b1, 1'b1, ON, 1'b0, 1'b1, 4'hf, a, 32'hbad0_bad0, 1'b1);
        bus(1'b1, 1'b1, 1'b1, ON, 1'b0, 1'b1, 4'hf, a, 32'h5555_aaaa, 1'b1);
        idle(1);
        ref_mem[a] = 32'h5555_aaaa;
        // both strobes low: the processor strobe wins, so no write happens
        bus(1'b0, 1'b0, 1'b1, ON, 1'b0, 1'b1, 4'hf, a + 16'h1, 32'hbad1_bad1, 1'b1);
        idle(1);
        rd(a, 2, 1'b0, 1'b0);
    endtask

    task automatic s_sleep(input logic [15:0] a);
        @(posedge clk_in);
        sleep <= 1'b1;
        idle(5);
        #1;
        check({30'h0, sleeping, dq_oe_n}, 32'h3);
        bus(1'b1, 1'b0, 1'b1, ON, 1'b0, 1'b1, 4'hf, a, 32'h0, 1'b1);
        idle(1);
        sleep <= 1'b0;
        idle(5);
        #1;
        check({31'h0, sleeping}, 32'h0);
        desel(3'h6);
        rd(a, 1, 1'b1, 1'b0);
    endtask

    initial begin
        repeat (5000) @(posedge clk_in);
        n_mismatch++;
        summarize();
    end

    initial begin
        do_reset(1'b1);
        s_fill(16'h5a4c);
        s_order(16'h5a4c, 3'h0);
        do_reset(1'b0);
        s_order(16'h5a4c, 3'h3);
        s_bytes(16'h0130);
        s_proc(16'h0222);
        s_sleep(16'h0130);
        summarize();
    end
endmodule
`default_nettype wire
